// ### src/dram_ctl_pkg.sv
package dram_ctl_pkg;

	// ==========================================
	// Array geometry
	localparam int ADDR_W = 9;
	localparam int DATA_W = 4;
	localparam int ROWS = 512;
	localparam int INIT_CYCLES = 8;

	// ==========================================
	// Clock and timing (figures in ns unless noted)
	localparam int CLK_PERIOD_NS = 5;
	localparam int ROW_TO_COLUMN_DELAY_NS = 25;
	localparam int COLUMN_TO_WRITE_DELAY_NS = 60;
	localparam int WRITE_TO_ROW_LEAD_NS = 30;
	localparam int WRITE_TO_COLUMN_LEAD_NS = 30;
	localparam int ROW_ACTIVE_MIN_NS = 120;
	localparam int COLUMN_ACTIVE_MIN_NS = 30;
	localparam int ROW_PRECHARGE_MIN_NS = 90;
	localparam int COLUMN_PRECHARGE_MIN_NS = 15;
	localparam int COLUMN_ACCESS_TIME_NS = 35;
	localparam int TRANSITION_TIME_NS = 5;
	localparam int REFRESH_INTERVAL_NS = 15600;
	localparam int POWERUP_PAUSE_NS = 200000;

	// Least times round up to whole cycles
	function automatic int cyc_up(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_up

	localparam int RCD_CYC = cyc_up(ROW_TO_COLUMN_DELAY_NS);
	localparam int CWD_CYC = cyc_up(COLUMN_TO_WRITE_DELAY_NS);
	localparam int RWL_CYC = cyc_up(WRITE_TO_ROW_LEAD_NS);
	localparam int CWL_CYC = cyc_up(WRITE_TO_COLUMN_LEAD_NS);
	localparam int RAS_CYC = cyc_up(ROW_ACTIVE_MIN_NS);
	localparam int CAS_CYC = cyc_up(COLUMN_ACTIVE_MIN_NS);
	localparam int RP_CYC = cyc_up(ROW_PRECHARGE_MIN_NS);
	localparam int CP_CYC = cyc_up(COLUMN_PRECHARGE_MIN_NS);
	localparam int CAC_CYC = cyc_up(COLUMN_ACCESS_TIME_NS);
	localparam int TT_CYC = cyc_up(TRANSITION_TIME_NS);
	// Longest interval rounds down
	localparam int REFRESH_CYC = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
	localparam int POWERUP_CYC = cyc_up(POWERUP_PAUSE_NS);

	localparam int CNT_W = 16;

	// ==========================================
	// Host commands
	typedef enum logic [1:0] {
		CMD_READ,
		CMD_WRITE,
		CMD_READ_WRITE,
		CMD_COUNTER_TEST
	} cmd_t;

endpackage : dram_ctl_pkg

// ### src/refresh_timer.sv
`timescale 1ns/1ps
`default_nettype none

module refresh_timer
	import dram_ctl_pkg::*;
#(
	parameter int INTERVAL = REFRESH_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Request handshake
	input wire logic enable,
	input wire logic taken,
	output logic pending
);

	logic [CNT_W-1:0] count_q;
	logic pending_q;

	// ==========================================
	// Interval counter
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count_q <= '0;
		end else if (!enable || count_q == CNT_W'(INTERVAL - 1)) begin
			count_q <= '0;
		end else begin
			count_q <= count_q + 1'b1;
		end
	end

	// ==========================================
	// Sticky request; a new tick wins over the take
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pending_q <= 1'b0;
		end else if (enable && count_q == CNT_W'(INTERVAL - 1)) begin
			pending_q <= 1'b1;
		end else if (taken) begin
			pending_q <= 1'b0;
		end
	end

	assign pending = pending_q;

endmodule : refresh_timer

`default_nettype wire

// ### src/dram_ctl.sv
// What this block does
// - Early write: write strobe low a setup time before column falls.
// - Late write strobe may lag column strobe, within row active time.
// - Read-write: write waits a column-to-write delay after column falls.
// - Page mode: row strobe held low, column strobe toggles per column.
// - Page starts with a normal access; column precharge between accesses.
// - All 512 rows refreshed within each 8 ms period.
// - One row refresh every 15.6 us (distributed refresh).
// - Hidden refresh: column low while row strobe precharges and falls.
// - At least eight column-before-row cycles precede the counter test.
// - Counter test sequence run by host through counter-test commands.
// - Row active, column active and row precharge minima kept in writes.
// - Late write keeps write-to-row and write-to-column leads.
// - Wait 200 us after power-up, then eight row strobe cycles.
// - Read keeps write strobe high through and after the strobe edges.
`timescale 1ns/1ps
`default_nettype none

module dram_ctl
	import dram_ctl_pkg::*;
#(
	parameter int POWERUP_WAIT = POWERUP_CYC,
	parameter int REFRESH_WAIT = REFRESH_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Host request
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [1:0] req_cmd,
	input wire logic [ADDR_W-1:0] req_row,
	input wire logic [ADDR_W-1:0] req_col,
	input wire logic [DATA_W-1:0] req_wdata,
	input wire logic req_last,
	// Host answer
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_rdata,
	output logic init_done,
	// Memory pins
	output logic [ADDR_W-1:0] mem_addr,
	output logic mem_ras_n,
	output logic mem_cas_n,
	output logic mem_we_n,
	output logic mem_oe_n,
	input wire logic [DATA_W-1:0] mem_dq_in,
	output logic [DATA_W-1:0] mem_dq_out,
	output logic mem_dq_oe
);

	typedef enum {
		ST_POWERUP, ST_WAKE, ST_IDLE, ST_ROW, ST_COL, ST_READ,
		ST_WRITE, ST_CAS_PRE, ST_ROW_END, ST_PRECHARGE, ST_CBR_CAS,
		ST_CBR_RAS
	} state_t;

	state_t state_q;
	logic [CNT_W-1:0] timer_q;
	logic [ADDR_W:0] ras_count_q;
	logic [CNT_W-1:0] ras_age_q;
	logic [1:0] cmd_q;
	logic [ADDR_W-1:0] row_q;
	logic [DATA_W-1:0] wdata_q;
	logic last_q;
	logic hidden_q;
	logic [DATA_W-1:0] dq_sync1_q;
	logic [DATA_W-1:0] dq_sync2_q;
	logic refresh_pending;
	logic refresh_taken;
	logic cbr_init;
	logic timer_done;
	logic powered;
	logic page_ready;

	function automatic logic is_write(input logic [1:0] cmd);
		return cmd != 2'(CMD_READ);
	endfunction : is_write

	function automatic logic reads_first(input logic [1:0] cmd);
		return cmd != 2'(CMD_WRITE);
	endfunction : reads_first

	assign timer_done = (timer_q == '0);
	assign powered = (state_q != ST_POWERUP) && (state_q != ST_WAKE);
	assign init_done = powered && cbr_init;
	assign cbr_init = (ras_count_q >= (ADDR_W+1)'(INIT_CYCLES));
	// Page continuation is offered once the CP_CYC timer of ST_CAS_PRE has run out
	assign page_ready = (state_q == ST_CAS_PRE) && !last_q && timer_done
		&& !refresh_pending && cmd_q != 2'(CMD_COUNTER_TEST)
		&& req_cmd != 2'(CMD_COUNTER_TEST);
	assign req_ready = ((state_q == ST_IDLE) && cbr_init && !refresh_pending)
		|| page_ready;
	assign refresh_taken = (state_q == ST_CBR_RAS) && timer_done;

	// ==========================================
	// Refresh interval: one row every 15.6 us
	refresh_timer #(
		.INTERVAL(REFRESH_WAIT)
	) u_refresh (
		.clk(clk),
		.reset_n(reset_n),
		.enable(powered),
		.taken(refresh_taken),
		.pending(refresh_pending)
	);

	// ==========================================
	// Read data synchroniser
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dq_sync1_q <= '0;
			dq_sync2_q <= '0;
		end else begin
			dq_sync1_q <= mem_dq_in;
			dq_sync2_q <= dq_sync1_q;
		end
	end

	// ==========================================
	// Cycles since last row strobe, for the wake-up rule
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ras_age_q <= '0;
		end else if (!mem_ras_n) begin
			ras_age_q <= '0;
		end else if (ras_age_q != '1) begin
			ras_age_q <= ras_age_q + 1'b1;
		end
	end

	// ==========================================
	// Row strobe cycles issued since wake-up, counted up to INIT_CYCLES
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ras_count_q <= '0;
		end else if (state_q == ST_POWERUP) begin
			ras_count_q <= '0;
		end else if (state_q == ST_PRECHARGE && timer_done && !cbr_init) begin
			ras_count_q <= ras_count_q + 1'b1;
		end
	end

	// ==========================================
	// Main sequencer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_POWERUP;
			timer_q <= CNT_W'(POWERUP_WAIT);
			mem_ras_n <= 1'b1;
			mem_cas_n <= 1'b1;
			mem_we_n <= 1'b1;
			mem_oe_n <= 1'b1;
			mem_addr <= '0;
			mem_dq_out <= '0;
			mem_dq_oe <= 1'b0;
			cmd_q <= 2'(CMD_READ);
			row_q <= '0;
			wdata_q <= '0;
			last_q <= 1'b1;
			hidden_q <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
		end else begin
			rsp_valid <= 1'b0;
			if (!timer_done) begin
				timer_q <= timer_q - 1'b1;
			end
			case (state_q)
			ST_POWERUP: begin
				if (timer_done) begin
					state_q <= ST_WAKE;
				end
			end
			ST_WAKE: begin
				// Wake-up cycles are column-before-row refreshes
				state_q <= ST_CBR_CAS;
				mem_cas_n <= 1'b0;
				timer_q <= CNT_W'(TT_CYC);
			end
			ST_IDLE: begin
				if (ras_age_q >= CNT_W'(REFRESH_WAIT)) begin
					state_q <= ST_POWERUP;
					timer_q <= '0;
				end else if (!cbr_init || refresh_pending) begin
					state_q <= ST_CBR_CAS;
					mem_cas_n <= 1'b0;
					timer_q <= CNT_W'(TT_CYC);
				end else if (req_valid) begin
					cmd_q <= req_cmd;
					row_q <= req_row;
					wdata_q <= req_wdata;
					last_q <= req_last;
					mem_dq_out <= req_wdata;
					mem_we_n <= 1'b1;
					if (req_cmd == 2'(CMD_COUNTER_TEST)) begin
						// Counter row: column strobe leads row strobe
						mem_addr <= req_col;
						mem_cas_n <= 1'b0;
						state_q <= ST_ROW;
						timer_q <= CNT_W'(TT_CYC);
					end else begin
						mem_addr <= req_row;
						state_q <= ST_ROW;
						timer_q <= CNT_W'(TT_CYC);
					end
				end
			end
			ST_ROW: begin
				if (timer_done) begin
					mem_ras_n <= 1'b0;
					state_q <= ST_COL;
					if (cmd_q == 2'(CMD_COUNTER_TEST)) begin
						// Column stays low past the row edge, then precharges
						timer_q <= CNT_W'(CAS_CYC + CP_CYC);
					end else begin
						timer_q <= CNT_W'(RCD_CYC);
					end
				end
			end
			ST_COL: begin
				mem_addr <= (cmd_q == 2'(CMD_COUNTER_TEST)) ? mem_addr : req_col;
				if (cmd_q == 2'(CMD_COUNTER_TEST)
						&& timer_q == CNT_W'(CP_CYC + 1)) begin
					// Counter test: column precharge before its access
					mem_cas_n <= 1'b1;
				end
				if (timer_done) begin
					mem_cas_n <= 1'b0;
					if (!reads_first(cmd_q)) begin
						// Early write: strobe and data ahead of column
						mem_we_n <= 1'b0;
						mem_dq_oe <= 1'b1;
						mem_oe_n <= 1'b1;
						state_q <= ST_WRITE;
						timer_q <= CNT_W'(CAS_CYC);
					end else begin
						mem_oe_n <= 1'b0;
						state_q <= ST_READ;
						// Late write needs the column-to-write delay too
						timer_q <= CNT_W'((CWD_CYC > CAC_CYC + 2)
								? CWD_CYC : CAC_CYC + 2);
					end
				end else if (!reads_first(cmd_q)) begin
					mem_we_n <= 1'b0;
					mem_dq_oe <= 1'b1;
				end
			end
			ST_READ: begin
				if (timer_done) begin
					rsp_valid <= 1'b1;
					rsp_rdata <= dq_sync2_q;
					if (is_write(cmd_q)) begin
						// Late write after column-to-write delay
						mem_oe_n <= 1'b1;
						mem_we_n <= 1'b0;
						mem_dq_out <= wdata_q;
						mem_dq_oe <= 1'b1;
						state_q <= ST_WRITE;
						timer_q <= CNT_W'((RWL_CYC > CWL_CYC) ? RWL_CYC : CWL_CYC);
					end else begin
						state_q <= ST_CAS_PRE;
						timer_q <= CNT_W'(CP_CYC);
					end
				end
			end
			ST_WRITE: begin
				if (timer_done) begin
					state_q <= ST_CAS_PRE;
					timer_q <= CNT_W'(CP_CYC);
				end
			end
			ST_CAS_PRE: begin
				mem_we_n <= 1'b1;
				mem_dq_oe <= 1'b0;
				mem_oe_n <= 1'b1;
				if (req_valid && page_ready) begin
					// Next column of the open page
					mem_cas_n <= 1'b1;
					cmd_q <= req_cmd;
					wdata_q <= req_wdata;
					mem_dq_out <= req_wdata;
					last_q <= req_last;
					state_q <= ST_COL;
					timer_q <= CNT_W'(CP_CYC);
				end else if (!last_q && !req_valid) begin
					mem_cas_n <= 1'b1;
				end else if (last_q || timer_done) begin
					hidden_q <= refresh_pending && !mem_cas_n;
					if (!(refresh_pending && !mem_cas_n)) begin
						mem_cas_n <= 1'b1;
					end
					state_q <= ST_ROW_END;
					timer_q <= CNT_W'(RAS_CYC);
				end
			end
			ST_ROW_END: begin
				if (timer_done) begin
					mem_ras_n <= 1'b1;
					state_q <= ST_PRECHARGE;
					timer_q <= CNT_W'(RP_CYC);
				end
			end
			ST_PRECHARGE: begin
				if (timer_done) begin
					if (hidden_q) begin
						// Column stays low; row falls again
						hidden_q <= 1'b0;
						state_q <= ST_CBR_RAS;
						mem_ras_n <= 1'b0;
						timer_q <= CNT_W'(RAS_CYC);
					end else begin
						mem_cas_n <= 1'b1;
						state_q <= ST_IDLE;
					end
				end
			end
			ST_CBR_CAS: begin
				if (timer_done) begin
					mem_ras_n <= 1'b0;
					state_q <= ST_CBR_RAS;
					timer_q <= CNT_W'(RAS_CYC);
				end
			end
			ST_CBR_RAS: begin
				if (timer_done) begin
					mem_ras_n <= 1'b1;
					mem_cas_n <= 1'b1;
					state_q <= ST_PRECHARGE;
					timer_q <= CNT_W'(RP_CYC);
				end
			end
			default: begin
				state_q <= ST_IDLE;
			end
			endcase
		end
	end

endmodule : dram_ctl

`default_nettype wire

// ### verification/dram_ctl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dram_ctl_monitor
	import dram_ctl_pkg::*;
#(
	parameter int POWERUP_WAIT = POWERUP_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Watched outputs
	input wire logic init_done,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic mem_ras_n,
	input wire logic mem_cas_n,
	input wire logic mem_we_n,
	input wire logic mem_dq_oe
);
	// ==========================================
	// Strobe level counters
	int rl_q, rh_q, cl_q, ch_q, wl_q, nf_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rl_q <= 0;
			rh_q <= 0;
			cl_q <= 0;
			ch_q <= 0;
			wl_q <= 0;
			nf_q <= 0;
		end else begin
			rl_q <= mem_ras_n ? 0 : rl_q + 1;
			rh_q <= mem_ras_n ? rh_q + 1 : 0;
			cl_q <= mem_cas_n ? 0 : cl_q + 1;
			ch_q <= mem_cas_n ? ch_q + 1 : 0;
			wl_q <= mem_we_n ? 0 : wl_q + 1;
			nf_q <= nf_q + int'(!mem_ras_n && rl_q == 0);
		end
	end
	// ==========================================
	// Rules
	sequence late_we_s;
		$fell(mem_we_n) && !mem_cas_n;
	endsequence
	sequence early_we_s;
		!mem_we_n && $fell(mem_cas_n);
	endsequence
	row_addr_a: assert property (
		$fell(mem_ras_n) && mem_cas_n |-> $stable(mem_addr))
		else $error("row address moved at row strobe");
	col_addr_a: assert property (
		$fell(mem_cas_n) && !mem_ras_n |-> $stable(mem_addr))
		else $error("column address moved at column strobe");
	row_col_a: assert property (
		$fell(mem_cas_n) && !mem_ras_n |-> rl_q >= RCD_CYC)
		else $error("row to column delay short");
	ras_min_a: assert property (
		$rose(mem_ras_n) |-> rl_q >= RAS_CYC)
		else $error("row strobe low too short");
	ras_pre_a: assert property (
		$fell(mem_ras_n) |-> rh_q >= RP_CYC)
		else $error("row precharge short");
	cas_min_a: assert property (
		$rose(mem_cas_n) |-> cl_q >= CAS_CYC)
		else $error("column strobe low too short");
	cas_pre_a: assert property (
		$fell(mem_cas_n) |-> ch_q >= CP_CYC)
		else $error("column precharge short");
	rw_delay_a: assert property (
		late_we_s |-> cl_q >= CWD_CYC)
		else $error("late write too soon");
	wr_data_a: assert property (
		(late_we_s or early_we_s) |-> mem_dq_oe)
		else $error("write data not driven");
	col_lead_a: assert property (
		$rose(mem_cas_n) && wl_q > 0 |-> wl_q >= CWL_CYC)
		else $error("write to column lead short");
	wake_count_a: assert property (
		$rose(init_done) |-> nf_q >= INIT_CYCLES)
		else $error("too few wake cycles");
	power_wait_a: assert property (
		$fell(mem_ras_n) && nf_q == 0 |-> rh_q >= POWERUP_WAIT)
		else $error("power-up pause short");
endmodule : dram_ctl_monitor
bind dram_ctl dram_ctl_monitor #(.POWERUP_WAIT(POWERUP_WAIT)) i_mon (
	.clk(clk), .reset_n(reset_n), .init_done(init_done), .mem_addr(mem_addr),
	.mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n),
	.mem_dq_oe(mem_dq_oe));
`default_nettype wire

// ### verification/dram_model.sv
`timescale 1ns/1ps
`default_nettype none
module dram_model
	import dram_ctl_pkg::*;
(
	// Sampling clock
	input wire logic clk,
	// Device pins
	input wire logic [ADDR_W-1:0] addr,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [DATA_W-1:0] d,
	input wire logic d_oe,
	output logic [DATA_W-1:0] q
);
	logic [DATA_W-1:0] mem [0:ROWS*512-1];
	logic [ADDR_W-1:0] row_q, col_q;
	logic [ADDR_W-1:0] cnt_q = 0;
	logic ras_q = 1;
	logic cas_q = 1;
	logic cbr_q = 0;
	logic rd_q = 0;
	logic [DATA_W-1:0] last_q = 0;
	wire logic drv = !cas_n && !cas_q && !oe_n && rd_q && !cbr_q;
	always @(posedge clk) begin
		ras_q <= ras_n;
		cas_q <= cas_n;
		if (ras_n || (!cas_q && cas_n)) cbr_q <= 0;
		if (ras_q && !ras_n) begin
			cbr_q <= !cas_n;
			row_q <= cas_n ? addr : cnt_q;
			cnt_q <= cnt_q + ADDR_W'(!cas_n);
		end
		if (cas_q && !cas_n && !ras_n) begin
			col_q <= addr;
			rd_q <= we_n;
		end
		// Cells are written while write strobe and data are both active
		if (!ras_n && !cas_n && !cas_q && !we_n && d_oe)
			mem[{row_q, col_q}] <= d;
		if (drv) last_q <= mem[{row_q, col_q}];
	end
	// Released lines show the inverse of the last value, or the last value itself during a column-before-row cycle
	assign q = drv ? mem[{row_q, col_q}]
		: (cbr_q ? last_q : ~last_q);
endmodule : dram_model
`default_nettype wire

// ### verification/dram_ctl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dram_ctl_tb;
	import dram_ctl_pkg::*;
	localparam int PW = 50;
	localparam int RW = 200;
	logic clk = 0;
	logic reset_n = 0;
	logic req_valid = 0;
	logic req_last = 1;
	logic [1:0] req_cmd = 0;
	logic [ADDR_W-1:0] req_row = 0;
	logic [ADDR_W-1:0] req_col = 0;
	logic [DATA_W-1:0] req_wdata = 0;
	logic req_ready, rsp_valid, init_done, mem_ras_n, mem_cas_n;
	logic mem_we_n, mem_oe_n, mem_dq_oe;
	logic [ADDR_W-1:0] mem_addr;
	logic [DATA_W-1:0] rsp_rdata, mem_dq_out, dq_in, rd;
	logic [ADDR_W-1:0] ta [3] = '{9'h000, 9'h1FF, 9'h0AA};
	int mismatches = 0;
	int samples_checked = 0;
	int n, i, k, falls, cbrs, f0, c0;
	always #2.5 clk = ~clk;
	always @(negedge mem_ras_n) begin
		falls++;
		if (!mem_cas_n) cbrs++;
	end
	dram_ctl #(.POWERUP_WAIT(PW), .REFRESH_WAIT(RW)) i_dut (
		.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
		.req_ready(req_ready), .req_cmd(req_cmd), .req_row(req_row),
		.req_col(req_col), .req_wdata(req_wdata), .req_last(req_last),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .init_done(init_done),
		.mem_addr(mem_addr), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
		.mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .mem_dq_in(dq_in),
		.mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe));
	dram_model i_mem (
		.clk(clk), .addr(mem_addr), .ras_n(mem_ras_n), .cas_n(mem_cas_n),
		.we_n(mem_we_n), .oe_n(mem_oe_n), .d(mem_dq_out), .d_oe(mem_dq_oe),
		.q(dq_in));
	// ==========================================
	// Shared tasks
	task results;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : results
	task check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task give_up;
		mismatches++;
		results();
	endtask : give_up
	task access(input logic [1:0] c, input logic [8:0] r, input logic [8:0] cl,
		input logic [3:0] w, input logic l);
		@(posedge clk);
		req_valid <= 1;
		req_cmd <= c;
		req_row <= r;
		req_col <= cl;
		req_wdata <= w;
		req_last <= l;
		@(negedge clk);
		for (n = 0; n < 900 && req_ready !== 1'b1; n++) @(negedge clk);
		if (req_ready !== 1'b1) give_up();
		@(posedge clk);
		req_valid <= 0;
		@(negedge clk);
		for (n = 0; n < 60 && mem_cas_n !== 1'b0; n++) @(negedge clk);
		if (mem_cas_n !== 1'b0) give_up();
		if (c != CMD_WRITE) begin
			for (n = 0; n < 60 && rsp_valid !== 1'b1; n++) @(negedge clk);
			if (rsp_valid !== 1'b1) give_up();
			rd = rsp_rdata;
		end
	endtask : access
	// ==========================================
	// Scenarios
	task t_init;
		for (n = 0; n < 3000 && init_done !== 1'b1; n++) @(negedge clk);
		check(init_done, 1);
		if (init_done !== 1'b1) give_up();
		$display("test init done");
	endtask : t_init
	task t_write_read;
		for (i = 0; i < 3; i++) access(CMD_WRITE, ta[i], ~ta[i], 4'h3 + i, 1);
		for (i = 0; i < 3; i++) begin
			access(CMD_READ, ta[i], ~ta[i], 0, 1);
			check(rd, 4'h3 + i);
		end
		$display("test write_read done");
	endtask : t_write_read
	task t_read_write;
		access(CMD_READ_WRITE, 9'h1FF, 9'h000, 4'hC, 1);
		check(rd, 4'h4);
		access(CMD_READ, 9'h1FF, 9'h000, 0, 1);
		check(rd, 4'hC);
		$display("test read_write done");
	endtask : t_read_write
	task t_page;
		for (k = 0; k < 4; k++) access(CMD_WRITE, 9'h055, k, 4'h8 + k, k == 3);
		for (k = 0; k < 4; k++) begin
			access(CMD_READ, 9'h055, k, 0, k == 3);
			check(rd, 4'h8 + k);
		end
		$display("test page done");
	endtask : t_page
	task t_refresh;
		f0 = falls;
		c0 = cbrs;
		repeat (RW * 3) @(posedge clk);
		check(falls - f0 >= 2, 1);
		check(falls - f0, cbrs - c0);
		access(CMD_READ, ta[2], ~ta[2], 0, 1);
		check(rd, 4'h5);
		$display("test refresh done");
	endtask : t_refresh
	task t_counter;
		for (i = 0; i < ROWS; i++) access(CMD_WRITE, i, 9'h005, 4'hA, 1);
		access(CMD_COUNTER_TEST, 0, 9'h005, 4'h5, 1);
		check(rd, 4'hA);
		k = 0;
		for (i = 0; i < ROWS; i++) begin
			access(CMD_READ, i, 9'h005, 0, 1);
			k += int'(rd === 4'h5);
		end
		check(k, 1);
		$display("test counter done");
	endtask : t_counter
	initial begin
		repeat (12) @(posedge clk);
		reset_n <= 1;
		t_init();
		t_write_read();
		t_read_write();
		t_page();
		t_refresh();
		t_counter();
		results();
	end
endmodule : dram_ctl_tb
`default_nettype wire
